// file: spdfp_defs.svh
// Purpose: Offsets, field positions and reset values of the post-divider block
// Assumes: Register byte address is four times the register index
// Notes:   Definitions only
`ifndef SPDFP_DEFS_SVH
`define SPDFP_DEFS_SVH

// ************************************************************
// Register indices of the three registers
// ************************************************************
`define SPDFP_IDX_S0D     8'h89
`define SPDFP_IDX_S1A     8'h8c
`define SPDFP_IDX_STAT    8'h92

// ************************************************************
// Control word fields
// ************************************************************
`define SPDFP_CW          24
`define SPDFP_KIND_HI     23
`define SPDFP_KIND_LO     20
`define SPDFP_BIT_STYLE   19
`define SPDFP_BIT_POL     18
`define SPDFP_KIND_ONES   4'hf
`define SPDFP_LF_S0D      2'h3
`define SPDFP_LF_S1A      2'h0

// ************************************************************
// Reset values and bus answers
// ************************************************************
`define SPDFP_RST_S0D     24'h000040
`define SPDFP_RST_S1A     24'h000002
`define SPDFP_RESP_OKAY   2'h0
`define SPDFP_RESP_SLVERR 2'h2

`endif

// file: spdfp_pkg.sv
// Purpose: Types shared by the post-divider block
// Assumes: Control word is 24 bits, kind field on top
// Notes:   Nothing here is imported; use spdfp_pkg::name
package spdfp_pkg;

   // ************************************************************
   // Control word layout
   // ************************************************************
   typedef struct packed {
      logic [3:0]  kind;
      logic        style;
      logic        pol;
      logic [1:0]  src;
      logic [15:0] rate;
   } spdfp_ctrl_type;

   // ************************************************************
   // Output kinds and register selects
   // ************************************************************
   typedef enum logic [1:0] {
      SPDFP_MODE_DIV,
      SPDFP_MODE_LF,
      SPDFP_MODE_FRAME
   } spdfp_mode_type;

   typedef enum logic [1:0] {
      SPDFP_SEL_D,
      SPDFP_SEL_A,
      SPDFP_SEL_STAT,
      SPDFP_SEL_NONE
   } spdfp_sel_type;

endpackage

// file: spdfp_axil_regs.sv
// Purpose: AXI4-Lite slave holding the two control words and serving a status word
// Assumes: One write and one read under way at a time
// Notes:   Unmapped addresses answer SLVERR; status writes are ignored
`timescale 1ns/10ps
`include "spdfp_defs.svh"
module spdfp_axil_regs #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   // Write channels
   input  wire logic [ADDR_W-1:0]     awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   // Read channels
   input  wire logic [ADDR_W-1:0]     araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   // Block side
   output spdfp_pkg::spdfp_ctrl_type  ctrl_d_r,
   output spdfp_pkg::spdfp_ctrl_type  ctrl_a_r,
   output logic [1:0]                 load_r,
   input  wire logic [31:0]           stat
);

   function automatic spdfp_pkg::spdfp_sel_type dec(input logic [ADDR_W-1:0] a);
      if (a[ADDR_W-1:2] == (ADDR_W-2)'(`SPDFP_IDX_S0D)) return spdfp_pkg::SPDFP_SEL_D;
      if (a[ADDR_W-1:2] == (ADDR_W-2)'(`SPDFP_IDX_S1A)) return spdfp_pkg::SPDFP_SEL_A;
      if (a[ADDR_W-1:2] == (ADDR_W-2)'(`SPDFP_IDX_STAT)) return spdfp_pkg::SPDFP_SEL_STAT;
      return spdfp_pkg::SPDFP_SEL_NONE;
   endfunction

   function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [23:0] m;
      m = old;
      for (int b = 0; b < 3; b++) begin
         if (s[b]) m[8*b +: 8] = d[8*b +: 8];
      end
      return m;
   endfunction

   // ************************************************************
   // Write path
   // ************************************************************
   logic                      aw_got_r, w_got_r, aw_have, w_have, wr_fire, bvalid_nxt;
   logic [ADDR_W-1:0]         awaddr_r, wr_addr;
   logic [31:0]               wdata_r, wr_data;
   logic [3:0]                wstrb_r, wr_strb;
   spdfp_pkg::spdfp_sel_type  wr_sel;

   // Address and data may come in either order; the held copy wins
   assign aw_have    = aw_got_r | (awvalid & awready);
   assign w_have     = w_got_r | (wvalid & wready);
   assign wr_fire    = aw_have & w_have;
   assign wr_addr    = aw_got_r ? awaddr_r : awaddr;
   assign wr_data    = w_got_r ? wdata_r : wdata;
   assign wr_strb    = w_got_r ? wstrb_r : wstrb;
   assign wr_sel     = dec(wr_addr);
   assign bvalid_nxt = wr_fire | (bvalid & ~bready);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= '0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
         awready  <= 1'b0;
         wready   <= 1'b0;
         bvalid   <= 1'b0;
         bresp    <= `SPDFP_RESP_OKAY;
      end else begin
         aw_got_r <= aw_have & ~wr_fire;
         w_got_r  <= w_have & ~wr_fire;
         if (awvalid & awready) awaddr_r <= awaddr;
         if (wvalid & wready) begin
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         awready <= ~(aw_have & ~wr_fire) & ~bvalid_nxt;
         wready  <= ~(w_have & ~wr_fire) & ~bvalid_nxt;
         bvalid  <= bvalid_nxt;
         if (wr_fire) begin
            bresp <= (wr_sel == spdfp_pkg::SPDFP_SEL_NONE) ? `SPDFP_RESP_SLVERR
                                                           : `SPDFP_RESP_OKAY;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ctrl_d_r <= `SPDFP_RST_S0D;
         ctrl_a_r <= `SPDFP_RST_S1A;
         load_r   <= 2'h0;
      end else begin
         load_r <= {wr_fire & (wr_sel == spdfp_pkg::SPDFP_SEL_A),
                    wr_fire & (wr_sel == spdfp_pkg::SPDFP_SEL_D)};
         if (wr_fire && wr_sel == spdfp_pkg::SPDFP_SEL_D) ctrl_d_r <= merge(ctrl_d_r, wr_data, wr_strb);
         if (wr_fire && wr_sel == spdfp_pkg::SPDFP_SEL_A) ctrl_a_r <= merge(ctrl_a_r, wr_data, wr_strb);
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   logic rvalid_nxt;
   assign rvalid_nxt = (arvalid & arready) | (rvalid & ~rready);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= `SPDFP_RESP_OKAY;
      end else begin
         arready <= ~rvalid_nxt;
         rvalid  <= rvalid_nxt;
         if (arvalid & arready) begin
            rresp <= `SPDFP_RESP_OKAY;
            unique case (dec(araddr))
               spdfp_pkg::SPDFP_SEL_D:    rdata <= {8'h00, ctrl_d_r};
               spdfp_pkg::SPDFP_SEL_A:    rdata <= {8'h00, ctrl_a_r};
               spdfp_pkg::SPDFP_SEL_STAT: rdata <= stat;
               spdfp_pkg::SPDFP_SEL_NONE: begin
                  rdata <= '0;
                  rresp <= `SPDFP_RESP_SLVERR;
               end
            endcase
         end
      end
   end

endmodule // spdfp_axil_regs

// file: spdfp_top.sv
// Purpose: Two configurable post-divider outputs: divided clock, low-frequency
//          clock or frame pulse, set by a 24-bit control word each
// Assumes: Synthesizer outputs arrive as one-cycle ticks, sibling clocks as
//          levels, all synchronous to core_clk
// Notes:   Channel 0 is the first synthesizer's divider D, channel 1 the
//          second synthesizer's divider A
//
// Contract
// - Bits 23:20 choose frame pulse, low-frequency clock or regular clock.
// - Divider D, kind all ones, source 11: clock at base2x over bits 15:0.
// - Divider D, kind all ones, other source: frame pulse one selected period wide.
// - Kind not all ones: clock at synthesizer over the whole word, high for half the word rounded up.
// - Frame mode bit 18 sets polarity; in regular mode it is a ratio bit, in low-frequency mode unused.
// - Frame mode bit 19: 0 centred boundary, 1 boundary at first edge.
// - Divider A frame mode: bits 15:0 count selected periods between pulses.
// - Divider A, kind all ones, source 00: clock at base2x over bits 15:0.
// - Divider A, regular mode: synthesizer divided by the whole 24-bit word.
// - Divider A source: 00 low-frequency, 01 B, 10 C, 11 D.
// - Outside all-ones kind, bits 17:16 are ratio bits, not a selector.
// - Divider D source: 00 A, 01 B, 10 C, 11 low-frequency.
`timescale 1ns/10ps
`include "spdfp_defs.svh"
module spdfp_top #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               nrst,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0]  awaddr,
   input  wire logic [2:0]         awprot,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0]  araddr,
   input  wire logic [2:0]         arprot,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   // Synthesizer ticks
   input  wire logic               first_synthesizer_tick,
   input  wire logic               first_synthesizer_base2x_tick,
   input  wire logic               second_synthesizer_tick,
   input  wire logic               second_synthesizer_base2x_tick,
   // Sibling post-divider clocks
   input  wire logic [2:0]         first_synthesizer_sib_clk,
   input  wire logic [2:0]         second_synthesizer_sib_clk,
   // Derived outputs
   output logic                    post_div_d_out,
   output logic                    post_div_a_out
);

   localparam logic [1:0] LF_CODE [2] = '{`SPDFP_LF_S0D, `SPDFP_LF_S1A};

   // ************************************************************
   // Decoding helpers
   // ************************************************************
   function automatic spdfp_pkg::spdfp_mode_type mode_of(input spdfp_pkg::spdfp_ctrl_type c,
                                                         input logic [1:0] lf);
      if (c.kind != `SPDFP_KIND_ONES) return spdfp_pkg::SPDFP_MODE_DIV;
      if (c.src == lf) return spdfp_pkg::SPDFP_MODE_LF;
      return spdfp_pkg::SPDFP_MODE_FRAME;
   endfunction

   // Sibling lines are packed in source order with the low-frequency code removed
   function automatic logic [1:0] sib_idx(input logic [1:0] src, input logic [1:0] lf);
      // Low-frequency code maps to line 0 so the index never leaves the vector
      if (src == lf) return 2'h0;
      return (src > lf) ? src - 2'h1 : src;
   endfunction

   // ************************************************************
   // Signals
   // ************************************************************
   spdfp_pkg::spdfp_ctrl_type  ctrl_w      [2];
   spdfp_pkg::spdfp_mode_type  mode_w      [2];
   logic [1:0]                 load_w;
   logic [31:0]                stat_w;
   logic                       synth_tick_w[2];
   logic                       base_tick_w [2];
   logic [2:0]                 sib_w       [2];
   logic [`SPDFP_CW-1:0]       n_w         [2];
   logic [`SPDFP_CW-1:0]       last_w      [2];
   logic [`SPDFP_CW-1:0]       half_w      [2];
   logic [`SPDFP_CW-1:0]       cnt_nxt_w   [2];
   logic [`SPDFP_CW-1:0]       cnt_r       [2];
   logic [1:0]                 tick_w;
   logic [1:0]                 wrap_w;
   logic [1:0]                 sel_lvl_w;
   logic [1:0]                 rise_w;
   logic [1:0]                 fall_w;
   logic [1:0]                 act_nxt_w;
   logic [1:0]                 sel_prev_r;
   logic [1:0]                 act_r;
   logic [1:0]                 out_r;

   assign synth_tick_w[0] = first_synthesizer_tick;
   assign synth_tick_w[1] = second_synthesizer_tick;
   assign base_tick_w[0]  = first_synthesizer_base2x_tick;
   assign base_tick_w[1]  = second_synthesizer_base2x_tick;
   assign sib_w[0]        = first_synthesizer_sib_clk;
   assign sib_w[1]        = second_synthesizer_sib_clk;
   assign post_div_d_out  = out_r[0];
   assign post_div_a_out  = out_r[1];
   assign stat_w          = {26'h0, 2'(mode_w[1]), 2'(mode_w[0]), out_r};

   // ************************************************************
   // Register bus
   // ************************************************************
   spdfp_axil_regs #(
      .ADDR_W   (ADDR_W)
   ) spdfp_axil_regs_i (
      .core_clk (core_clk),
      .nrst     (nrst),
      .awaddr   (awaddr),
      .awvalid  (awvalid),
      .awready  (awready),
      .wdata    (wdata),
      .wstrb    (wstrb),
      .wvalid   (wvalid),
      .wready   (wready),
      .bresp    (bresp),
      .bvalid   (bvalid),
      .bready   (bready),
      .araddr   (araddr),
      .arvalid  (arvalid),
      .arready  (arready),
      .rdata    (rdata),
      .rresp    (rresp),
      .rvalid   (rvalid),
      .rready   (rready),
      .ctrl_d_r (ctrl_w[0]),
      .ctrl_a_r (ctrl_w[1]),
      .load_r   (load_w),
      .stat     (stat_w)
   );

   // ************************************************************
   // Output channels
   // ************************************************************
   for (genvar i = 0; i < 2; i++) begin : g_chan
      logic [`SPDFP_CW-1:0] n_eff;

      always_comb begin
         mode_w[i] = mode_of(ctrl_w[i], LF_CODE[i]);
         sel_lvl_w[i] = sib_w[i][sib_idx(ctrl_w[i].src, LF_CODE[i])];
         rise_w[i]    = sel_lvl_w[i] & ~sel_prev_r[i];
         fall_w[i]    = ~sel_lvl_w[i] & sel_prev_r[i];
         unique case (mode_w[i])
            spdfp_pkg::SPDFP_MODE_DIV: begin
               n_w[i]    = ctrl_w[i];
               tick_w[i] = synth_tick_w[i];
            end
            spdfp_pkg::SPDFP_MODE_LF: begin
               n_w[i]    = {8'h00, ctrl_w[i].rate};
               tick_w[i] = base_tick_w[i];
            end
            spdfp_pkg::SPDFP_MODE_FRAME: begin
               n_w[i]    = {8'h00, ctrl_w[i].rate};
               tick_w[i] = rise_w[i];
            end
         endcase
         // A zero ratio is taken as one to keep the counter bounded
         n_eff        = (n_w[i] == '0) ? `SPDFP_CW'(1) : n_w[i];
         last_w[i]    = n_eff - `SPDFP_CW'(1);
         half_w[i]    = `SPDFP_CW'((25'(n_eff) + 25'h1) >> 1);
         wrap_w[i]    = (cnt_r[i] >= last_w[i]);
         cnt_nxt_w[i] = wrap_w[i] ? '0 : cnt_r[i] + `SPDFP_CW'(1);
         if (ctrl_w[i].style) begin
            act_nxt_w[i] = rise_w[i] ? wrap_w[i] : act_r[i];
         end else begin
            act_nxt_w[i] = fall_w[i] ? (cnt_r[i] == last_w[i]) : act_r[i];
         end
      end

      always_ff @(posedge core_clk) begin
         if (!nrst) begin
            cnt_r[i] <= '0;
         end else if (load_w[i]) begin
            cnt_r[i] <= '0;
         end else if (tick_w[i]) begin
            cnt_r[i] <= cnt_nxt_w[i];
         end
      end

      always_ff @(posedge core_clk) begin
         if (!nrst) begin
            sel_prev_r[i] <= 1'b0;
         end else begin
            sel_prev_r[i] <= sel_lvl_w[i];
         end
      end

      always_ff @(posedge core_clk) begin
         if (!nrst) begin
            // Reset words are divide mode; start high as after a load
            act_r[i] <= 1'b0;
            out_r[i] <= 1'b1;
         end else if (load_w[i]) begin
            act_r[i] <= 1'b0;
            out_r[i] <= (mode_w[i] == spdfp_pkg::SPDFP_MODE_FRAME) ? ctrl_w[i].pol : 1'b1;
         end else if (mode_w[i] == spdfp_pkg::SPDFP_MODE_FRAME) begin
            act_r[i] <= act_nxt_w[i];
            out_r[i] <= act_nxt_w[i] ^ ctrl_w[i].pol;
         end else begin
            act_r[i] <= 1'b0;
            if (tick_w[i]) begin
               out_r[i] <= (cnt_nxt_w[i] < half_w[i]);
            end
         end
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   property p_kind_div;
      (ctrl_w[1].kind != `SPDFP_KIND_ONES) |-> (mode_w[1] == spdfp_pkg::SPDFP_MODE_DIV);
   endproperty
   a_kind_div: assert property (p_kind_div)
      else $error("kind not all ones but mode is not divide");

   property p_lf_d;
      (mode_w[0] == spdfp_pkg::SPDFP_MODE_LF) && !load_w[0] && ctrl_w[0].rate == 16'h0002
         && first_synthesizer_base2x_tick ##1 !load_w[0] |-> post_div_d_out != $past(post_div_d_out);
   endproperty
   a_lf_d: assert property (p_lf_d)
      else $error("low-frequency output of divider D did not toggle");

   property p_frame_width;
      (mode_w[0] == spdfp_pkg::SPDFP_MODE_FRAME) && ctrl_w[0].style && !load_w[0]
         && rise_w[0] && wrap_w[0] |=> (act_r[0] && post_div_d_out == !ctrl_w[0].pol);
   endproperty
   a_frame_width: assert property (p_frame_width)
      else $error("frame pulse not started at boundary");

   property p_div2;
      (mode_w[1] == spdfp_pkg::SPDFP_MODE_DIV) && ctrl_w[1] == 24'h000002 && !load_w[1]
         && second_synthesizer_tick ##1 !load_w[1] |-> post_div_a_out != $past(post_div_a_out);
   endproperty
   a_div2: assert property (p_div2)
      else $error("divide-by-two output did not toggle on tick");

   property p_polarity;
      (mode_w[1] == spdfp_pkg::SPDFP_MODE_FRAME) && !load_w[1] && !$past(load_w[1])
         |-> (post_div_a_out == (act_r[1] ^ ctrl_w[1].pol));
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("frame pulse polarity wrong");

   property p_centred;
      (mode_w[0] == spdfp_pkg::SPDFP_MODE_FRAME) && !ctrl_w[0].style && !load_w[0]
         && fall_w[0] && cnt_r[0] == last_w[0] |=> act_r[0];
   endproperty
   a_centred: assert property (p_centred)
      else $error("centred pulse not raised half a period before boundary");

   property p_spacing;
      (mode_w[1] == spdfp_pkg::SPDFP_MODE_FRAME) && !load_w[1] && rise_w[1]
         && cnt_r[1] < last_w[1] |=> cnt_r[1] == $past(cnt_r[1]) + 24'h000001;
   endproperty
   a_spacing: assert property (p_spacing)
      else $error("frame spacing counter did not advance");

   property p_lf_a_src;
      (ctrl_w[1].kind == `SPDFP_KIND_ONES) && ctrl_w[1].src == 2'h0
         |-> (mode_w[1] == spdfp_pkg::SPDFP_MODE_LF) && tick_w[1] == second_synthesizer_base2x_tick;
   endproperty
   a_lf_a_src: assert property (p_lf_a_src)
      else $error("divider A source 00 not the low-frequency clock");

   property p_full_word;
      (mode_w[1] == spdfp_pkg::SPDFP_MODE_DIV) |-> n_w[1] == {ctrl_w[1].kind,
         ctrl_w[1].style, ctrl_w[1].pol, ctrl_w[1].src, ctrl_w[1].rate};
   endproperty
   a_full_word: assert property (p_full_word)
      else $error("regular mode ratio is not the whole word");

   property p_sel_a;
      (mode_w[1] == spdfp_pkg::SPDFP_MODE_FRAME) && ctrl_w[1].src == 2'h1
         |-> sel_lvl_w[1] == second_synthesizer_sib_clk[0];
   endproperty
   a_sel_a: assert property (p_sel_a)
      else $error("divider A source 01 not sibling B");

   property p_src_ratio;
      (mode_w[0] == spdfp_pkg::SPDFP_MODE_DIV) |-> n_w[0][17:16] == ctrl_w[0].src;
   endproperty
   a_src_ratio: assert property (p_src_ratio)
      else $error("source bits not used as ratio bits");

   property p_sel_d;
      (mode_w[0] == spdfp_pkg::SPDFP_MODE_FRAME) && ctrl_w[0].src == 2'h2
         |-> sel_lvl_w[0] == first_synthesizer_sib_clk[2];
   endproperty
   a_sel_d: assert property (p_sel_d)
      else $error("divider D source 10 not sibling C");

   property p_restart;
      load_w[0] |=> (cnt_r[0] == '0) && !act_r[0];
   endproperty
   a_restart: assert property (p_restart)
      else $error("counter did not restart after a write");

endmodule // spdfp_top

// file: spdfp_sink.sv
// Purpose: Downstream consumer that times one derived output
// Assumes: Output is synchronous to core_clk
// Notes:   Reports last period and high time, in cycles
`timescale 1ns/10ps
module spdfp_sink (
   // Clock and reset
   input  wire logic  core_clk,
   input  wire logic  nrst,
   // Observed output and results
   input  wire logic  sig,
   output logic [7:0] period_r,
   output logic [7:0] high_r
);
   // ****************************************
   // Edge timing
   // ****************************************
   logic [7:0] cnt_r;
   logic [7:0] hcnt_r;
   logic       last_r;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         {period_r, high_r, cnt_r, hcnt_r, last_r} <= '0;
      end else begin
         last_r <= sig;
         if (sig && !last_r) begin
            period_r <= cnt_r;
            high_r   <= hcnt_r;
            cnt_r    <= 8'h01;
            hcnt_r   <= 8'h01;
         end else begin
            cnt_r  <= cnt_r + 8'h01;
            hcnt_r <= hcnt_r + {7'h00, sig};
         end
      end
   end
endmodule // spdfp_sink

// file: tb_synth_post_divider_frame_pulse.sv
// Purpose: Register and output checks of the post-divider block
// Assumes: Base ticks every cycle, output ticks every other cycle
// Notes:   Top sibling line runs at an eight-cycle period, the others at four
`timescale 1ns/10ps
`include "spdfp_defs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
   $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_synth_post_divider_frame_pulse;
   logic core_clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic rready = 0, tk = 0, dout, aout, awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [1:0]  bresp, rresp;
   logic [2:0]  sc = '0;
   logic [7:0]  dp, dh, ap, ah;
   int err_count = 0, total_checks = 0, cyc = 0;
   localparam logic [11:0] AD = {2'b00, `SPDFP_IDX_S0D, 2'b00};
   localparam logic [11:0] AA = {2'b00, `SPDFP_IDX_S1A, 2'b00};
   initial forever #5 core_clk = ~core_clk;
   // ****************************************
   // Design, consumers and tick sources
   // ****************************************
   spdfp_top spdfp_top_i (.core_clk(core_clk), .nrst(nrst), .awaddr(awaddr),
      .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .first_synthesizer_tick(tk), .first_synthesizer_base2x_tick(1'b1),
      .second_synthesizer_tick(tk), .second_synthesizer_base2x_tick(1'b1),
      .first_synthesizer_sib_clk({sc[2], sc[1], sc[1]}),
      .second_synthesizer_sib_clk({sc[2], sc[1], sc[1]}),
      .post_div_d_out(dout), .post_div_a_out(aout));
   spdfp_sink d_sink_i (.core_clk(core_clk), .nrst(nrst), .sig(dout), .period_r(dp),
      .high_r(dh));
   spdfp_sink a_sink_i (.core_clk(core_clk), .nrst(nrst), .sig(aout), .period_r(ap),
      .high_r(ah));
   always @(posedge core_clk) begin
      tk <= ~tk;
      sc <= sc + 3'h1;
      cyc++;
      if (cyc > 6000) begin
         err_count++;
         stop_test();
      end
   end
   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      forever begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge core_clk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      forever begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      `CHK(rdata, e)
      `CHK(rresp, r)
      rready <= 1'b0;
   endtask
   // Write, let the output settle, compare period and high time
   task automatic meas(input logic [11:0] a, input logic [31:0] d, input logic [7:0] p,
                       input logic [7:0] h);
      wr(a, d);
      repeat (60) @(posedge core_clk);
      `CHK((a == AD) ? {dp, dh} : {ap, ah}, {p, h})
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      rd(AD, {8'h00, `SPDFP_RST_S0D}, `SPDFP_RESP_OKAY);
      rd(AA, {8'h00, `SPDFP_RST_S1A}, `SPDFP_RESP_OKAY);
      rd(12'h004, 32'h0, `SPDFP_RESP_SLVERR);
      wr(12'h004, 32'h00000007);
      `CHK(bresp, `SPDFP_RESP_SLVERR)
      meas(AD, 32'h00000004, 8'h08, 8'h04);
      meas(AA, 32'h00000003, 8'h06, 8'h04);
      rd(AA, 32'h00000003, `SPDFP_RESP_OKAY);
      meas(AD, 32'h00f30002, 8'h02, 8'h01);
      meas(AA, 32'h00f00005, 8'h05, 8'h03);
      meas(AD, 32'h00f00002, 8'h08, 8'h04);
      meas(AD, 32'h00fa0002, 8'h10, 8'h08);
      meas(AA, 32'h00f10004, 8'h10, 8'h04);
      meas(AA, 32'h00f50004, 8'h10, 8'h0c);
      meas(AA, 32'h00f90004, 8'h10, 8'h04);
      stop_test();
   end
endmodule // tb_synth_post_divider_frame_pulse
